// [logic/mbi_host.sv]
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// (R1) device wakes on each input change
// (R2) device latches outputs, returns to standby
// (R3) device stays standby while inputs stable
// (R4) inactive select forces device standby
// (R5) program reads use program-space strobe
// (R6) write pin: strobe or direction select
// (R7) read pin: strobe or enable clock
// (R8) select low only while device addressed
// (R9) shared pin otherwise carries extra address
// (R10) reset polarity selectable, held 100 ns
// (R11) low-voltage: active-low, 500 ns, 500 ns idle
// (R12) latch strobe polarity, trailing edge captures
// (R13) lanes carry address, then data
// (R14) device port direction per bit
// (R15) first port may output latched address
// (R16) second-port selects: four or two terms
// (R17) third-port inputs feed decoder
// (R18) third-port outputs use one term
// (R19) reset deselects all decoder outputs
// (R20) device drives lanes only during reads
module mbi_host (
    input wire logic clk_i,                           // system clock
    input wire logic sys_rst_i,                       // synchronous reset, active high
    input wire logic [7:0] s_awaddr_i,                // axi write address
    input wire logic s_awvalid_i,                     // axi write address valid
    output logic s_awready_o,                         // axi write address ready
    input wire logic [31:0] s_wdata_i,                // axi write data
    input wire logic [3:0] s_wstrb_i,                 // axi write strobes
    input wire logic s_wvalid_i,                      // axi write data valid
    output logic s_wready_o,                          // axi write data ready
    output logic [1:0] s_bresp_o,                     // axi write response
    output logic s_bvalid_o,                          // axi write response valid
    input wire logic s_bready_i,                      // axi write response ready
    input wire logic [7:0] s_araddr_i,                // axi read address
    input wire logic s_arvalid_i,                     // axi read address valid
    output logic s_arready_o,                         // axi read address ready
    output logic [31:0] s_rdata_o,                    // axi read data
    output logic [1:0] s_rresp_o,                     // axi read response
    output logic s_rvalid_o,                          // axi read valid
    input wire logic s_rready_i,                      // axi read ready
    input wire logic [7:0] mux_byte_lanes_i,          // lanes as seen on the wire
    output logic [7:0] mux_byte_lanes_o,              // lanes driven value
    output logic mux_byte_lanes_oe_o,                 // lanes driven when high
    output logic [7:0] high_order_address_inputs_o,   // address bits 15:8
    output logic address_latch_strobe_o,              // latch strobe, polarity by config
    output logic write_ctl_o,                         // write strobe or direction select
    output logic read_ctl_o,                          // read strobe or enable clock
    output logic program_space_read_strobe_o,         // program read strobe, active low
    output logic select_or_extra_address_pin_o,       // chip select or address bit 16
    output logic dev_reset_o                          // device reset, polarity by config
);
    // ----------------------------------------
    // register bus
    // ----------------------------------------
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic wr_ok;
    logic rd_ok;
    logic [5:0] ctrl;
    logic [16:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    mbi_axil_slave u_slave (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .awaddr_i(s_awaddr_i),
        .awvalid_i(s_awvalid_i),
        .awready_o(s_awready_o),
        .wdata_i(s_wdata_i),
        .wstrb_i(s_wstrb_i),
        .wvalid_i(s_wvalid_i),
        .wready_o(s_wready_o),
        .bresp_o(s_bresp_o),
        .bvalid_o(s_bvalid_o),
        .bready_i(s_bready_i),
        .araddr_i(s_araddr_i),
        .arvalid_i(s_arvalid_i),
        .arready_o(s_arready_o),
        .rdata_o(s_rdata_o),
        .rresp_o(s_rresp_o),
        .rvalid_o(s_rvalid_o),
        .rready_i(s_rready_i),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb),
        .wr_ok_i(wr_ok),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_ok_i(rd_ok)
    );

    mbi_pkg::mbi_state_t st;
    mbi_pkg::mbi_state_t next_st;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic cyc_read;
    logic cyc_prog;

    assign wr_ok = (wr_addr <= mbi_pkg::REG_STATUS) && (wr_addr[1:0] == 2'h0);
    assign rd_ok = (rd_addr <= mbi_pkg::REG_STATUS) && (rd_addr[1:0] == 2'h0);

    // decode for reads; status shows the engine's own state
    always_comb begin
        unique case (rd_addr)
            mbi_pkg::REG_CTRL: rd_data = {26'h0, ctrl};
            mbi_pkg::REG_ADDR: rd_data = {15'h0, addr};
            mbi_pkg::REG_WDATA: rd_data = {24'h0, wdata};
            mbi_pkg::REG_STATUS: rd_data = {16'h0, rdata, 6'h0,
                (st == mbi_pkg::ST_RST_ON), (st != mbi_pkg::ST_IDLE)};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    logic wr_cmd;
    logic go_write;
    logic go_read;
    logic go_prog;
    logic go_reset;

    // commands are only taken while idle; otherwise dropped, status shows busy
    assign wr_cmd = wr_en && wr_strb[0] && (wr_addr == mbi_pkg::REG_CMD)
        && (st == mbi_pkg::ST_IDLE);
    assign go_reset = wr_cmd && wr_data[mbi_pkg::CMD_RESET];
    assign go_prog = wr_cmd && !go_reset && wr_data[mbi_pkg::CMD_PROG];
    assign go_read = wr_cmd && !go_reset && !go_prog && wr_data[mbi_pkg::CMD_READ];
    assign go_write = wr_cmd && !go_reset && !go_prog && !go_read
        && wr_data[mbi_pkg::CMD_WRITE];

    // configuration registers, low byte lane only except the address, which takes lanes 0 to 2
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl <= mbi_pkg::CTRL_RESET;
            addr <= 17'h00000;
            wdata <= 8'h00;
        end else if (wr_en) begin
            if (wr_addr == mbi_pkg::REG_CTRL && wr_strb[0]) begin
                ctrl <= wr_data[5:0];
            end
            if (wr_addr == mbi_pkg::REG_ADDR) begin
                if (wr_strb[0]) addr[7:0] <= wr_data[7:0];
                if (wr_strb[1]) addr[15:8] <= wr_data[15:8];
                if (wr_strb[2]) addr[16] <= wr_data[16];
            end
            if (wr_addr == mbi_pkg::REG_WDATA && wr_strb[0]) begin
                wdata <= wr_data[7:0];
            end
        end
    end

    // ----------------------------------------
    // bus cycle sequencer
    // ----------------------------------------
    // each state lasts its own count; the count is the phase divider
    always_comb begin
        next_st = st;
        next_cnt = (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
        unique case (st)
            mbi_pkg::ST_IDLE: begin
                if (go_reset) begin
                    next_st = mbi_pkg::ST_RST_ON;
                    next_cnt = (ctrl[mbi_pkg::CTRL_LV] ? mbi_pkg::RST_LV_CYC
                        : mbi_pkg::RST_MIN_CYC) - 8'h01;     // [R10] [R11]
                end else if (go_write || go_read || go_prog) begin
                    next_st = mbi_pkg::ST_ADDR;
                    next_cnt = mbi_pkg::PHASE_CYC - 8'h01;
                end
            end
            mbi_pkg::ST_RST_ON: if (cnt == 8'h00) begin
                next_st = ctrl[mbi_pkg::CTRL_LV] ? mbi_pkg::ST_RST_QUIET : mbi_pkg::ST_IDLE;
                next_cnt = mbi_pkg::QUIET_LV_CYC - 8'h01;   // [R11]
            end
            mbi_pkg::ST_RST_QUIET: if (cnt == 8'h00) next_st = mbi_pkg::ST_IDLE;
            mbi_pkg::ST_ADDR: if (cnt == 8'h00) begin
                next_st = mbi_pkg::ST_LATCH;
                next_cnt = mbi_pkg::PHASE_CYC - 8'h01;
            end
            mbi_pkg::ST_LATCH: if (cnt == 8'h00) begin
                next_st = mbi_pkg::ST_STROBE;
                next_cnt = mbi_pkg::PHASE_CYC - 8'h01;
            end
            mbi_pkg::ST_STROBE: if (cnt == 8'h00) begin
                next_st = mbi_pkg::ST_RECOVER;
                next_cnt = mbi_pkg::PHASE_CYC - 8'h01;
            end
            mbi_pkg::ST_RECOVER: if (cnt == 8'h00) next_st = mbi_pkg::ST_IDLE;
        endcase
    end

    // state and phase count; the device is reset after our own reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= mbi_pkg::ST_RST_ON;
            cnt <= mbi_pkg::RST_LV_CYC - 8'h01;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
        end
    end

    // cycle kind, fixed for the whole cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cyc_read <= 1'b0;
            cyc_prog <= 1'b0;
        end else if (st == mbi_pkg::ST_IDLE) begin
            cyc_read <= go_read || go_prog;
            cyc_prog <= go_prog;
        end
    end

    // read data is sampled at the end of the strobe, while still active
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata <= 8'h00;
        end else if (st == mbi_pkg::ST_STROBE && cnt == 8'h00 && cyc_read) begin
            rdata <= mux_byte_lanes_i;   // [R13]
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    logic n_cyc;
    logic n_addr_ph;
    logic n_strobe;
    logic n_read;
    logic n_prog;

    assign n_cyc = (next_st == mbi_pkg::ST_ADDR) || (next_st == mbi_pkg::ST_LATCH)
        || (next_st == mbi_pkg::ST_STROBE) || (next_st == mbi_pkg::ST_RECOVER);
    assign n_addr_ph = (next_st == mbi_pkg::ST_ADDR) || (next_st == mbi_pkg::ST_LATCH);
    assign n_strobe = (next_st == mbi_pkg::ST_STROBE);
    assign n_read = (st == mbi_pkg::ST_IDLE) ? (go_read || go_prog) : cyc_read;
    assign n_prog = (st == mbi_pkg::ST_IDLE) ? go_prog : cyc_prog;

    // pins are registered from the next state so they move with it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mux_byte_lanes_o <= 8'h00;
            mux_byte_lanes_oe_o <= 1'b0;
            high_order_address_inputs_o <= 8'h00;
            address_latch_strobe_o <= 1'b0;
            write_ctl_o <= 1'b1;
            read_ctl_o <= 1'b1;
            program_space_read_strobe_o <= 1'b1;
            select_or_extra_address_pin_o <= 1'b1;
            dev_reset_o <= 1'b1;
        end else begin
            mux_byte_lanes_o <= n_addr_ph ? addr[7:0] : wdata;              // [R13]
            mux_byte_lanes_oe_o <= n_addr_ph || (n_cyc && !n_read);         // [R20]
            high_order_address_inputs_o <= addr[15:8];
            // address held steady across the trailing edge of the strobe
            address_latch_strobe_o <= (next_st == mbi_pkg::ST_ADDR)
                ~^ ctrl[mbi_pkg::CTRL_ALE_HI];                              // [R12]
            write_ctl_o <= ctrl[mbi_pkg::CTRL_WR_RW] ? !(n_cyc && !n_read)
                : !(n_strobe && !n_read);                                   // [R6]
            read_ctl_o <= ctrl[mbi_pkg::CTRL_RD_E] ? n_strobe
                : !(n_strobe && n_read && !n_prog);                         // [R7]
            program_space_read_strobe_o <= !(n_strobe && n_prog);           // [R5]
            // select stays high between cycles so the device sits in standby
            select_or_extra_address_pin_o <= ctrl[mbi_pkg::CTRL_CS_MODE]
                ? !n_cyc : addr[16];                                        // [R8] [R4] [R9]
            // low-voltage parts only take an active-low reset
            dev_reset_o <= (next_st == mbi_pkg::ST_RST_ON) ~^
                (ctrl[mbi_pkg::CTRL_RST_HI] && !ctrl[mbi_pkg::CTRL_LV]);  // [R10] [R11]
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [7:0] rst_held;
    logic [7:0] quiet;
    logic rst_act;

    assign rst_act = (st == mbi_pkg::ST_RST_ON);

    // cycles of reset drive, and cycles since its release
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rst_held <= 8'h00;
            quiet <= 8'h00;
        end else begin
            rst_held <= rst_act ? rst_held + 8'h01 : 8'h00;
            quiet <= rst_act ? 8'h00 : ((quiet != 8'hFF) ? quiet + 8'h01 : quiet);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_lanes_released: assert property ((st == mbi_pkg::ST_STROBE && cyc_read)
        |-> !mux_byte_lanes_oe_o) else $error("lanes driven during read"); // [R20]
    a_ale_trailing: assert property ((st == mbi_pkg::ST_LATCH && $past(st) == mbi_pkg::ST_ADDR)
        |-> mux_byte_lanes_oe_o && $stable(mux_byte_lanes_o)
        && address_latch_strobe_o == !ctrl[mbi_pkg::CTRL_ALE_HI])
        else $error("address moved at latch edge"); // [R12]
    a_wr_strobe: assert property ((!ctrl[mbi_pkg::CTRL_WR_RW] && !write_ctl_o)
        |-> st == mbi_pkg::ST_STROBE && !cyc_read) else $error("stray write strobe"); // [R6]
    a_rw_level: assert property ((ctrl[mbi_pkg::CTRL_WR_RW] && st == mbi_pkg::ST_STROBE)
        |-> write_ctl_o == cyc_read) else $error("direction select wrong"); // [R6]
    a_rd_style: assert property ((ctrl[mbi_pkg::CTRL_RD_E] && $stable(ctrl))
        |-> read_ctl_o == (st == mbi_pkg::ST_STROBE)) else $error("enable clock wrong"); // [R7]
    a_prog_strobe: assert property (!program_space_read_strobe_o
        |-> st == mbi_pkg::ST_STROBE && cyc_prog && read_ctl_o)
        else $error("program strobe misplaced"); // [R5]
    a_cs_select: assert property ((ctrl[mbi_pkg::CTRL_CS_MODE] && st == mbi_pkg::ST_IDLE)
        |-> select_or_extra_address_pin_o) else $error("select left active"); // [R8]
    a_rst_hold: assert property ($fell(rst_act) |-> rst_held >= (ctrl[mbi_pkg::CTRL_LV]
        ? mbi_pkg::RST_LV_CYC : mbi_pkg::RST_MIN_CYC)) else $error("reset too short"); // [R10]
    a_lv_quiet: assert property ((ctrl[mbi_pkg::CTRL_LV] && $rose(st == mbi_pkg::ST_ADDR))
        |-> quiet > mbi_pkg::QUIET_LV_CYC && !dev_reset_o == 1'b0)
        else $error("bus used too soon"); // [R11]
    a_strobe_len: assert property ($rose(st == mbi_pkg::ST_STROBE)
        |-> (st == mbi_pkg::ST_STROBE)[*3] ##1 st == mbi_pkg::ST_RECOVER)
        else $error("strobe phase length wrong"); // [R13]

    c_write: cover property (st == mbi_pkg::ST_STROBE && !cyc_read);
    c_read: cover property (st == mbi_pkg::ST_STROBE && cyc_read && !cyc_prog);
    c_prog: cover property (st == mbi_pkg::ST_STROBE && cyc_prog);
    c_reset: cover property ($fell(rst_act));

endmodule

`default_nettype wire

// [inc/mbi_pkg.sv]
package mbi_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 10;        // 100 MHz system clock
    localparam int PHASE_NS = 30;      // each bus phase, least time
    localparam int RST_MIN_NS = 100;   // least reset width, standard variant
    localparam int RST_LV_NS = 500;    // least reset width, low-voltage variant
    localparam int QUIET_LV_NS = 500;  // idle time after low-voltage reset
    localparam logic [7:0] PHASE_CYC = 8'((PHASE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] RST_MIN_CYC = 8'((RST_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] RST_LV_CYC = 8'((RST_LV_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] QUIET_LV_CYC = 8'((QUIET_LV_NS + CLK_NS - 1) / CLK_NS);

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // control bits
    localparam int CTRL_WR_RW = 0;     // 1: direction select, 0: write strobe
    localparam int CTRL_RD_E = 1;      // 1: enable clock, 0: read strobe
    localparam int CTRL_ALE_HI = 2;    // 1: latch strobe active high
    localparam int CTRL_CS_MODE = 3;   // 1: shared pin is chip select
    localparam int CTRL_RST_HI = 4;    // 1: device reset active high, unless CTRL_LV is set
    localparam int CTRL_LV = 5;        // 1: low-voltage variant
    localparam logic [5:0] CTRL_RESET = 6'h14;

    // command bits
    localparam int CMD_WRITE = 0;
    localparam int CMD_READ = 1;
    localparam int CMD_PROG = 2;
    localparam int CMD_RESET = 3;

    // status bits
    localparam int STAT_BUSY = 0;
    localparam int STAT_RST = 1;
    localparam int STAT_DATA = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RST_ON, ST_RST_QUIET, ST_ADDR, ST_LATCH, ST_STROBE, ST_RECOVER
    } mbi_state_t;

endpackage

// [logic/mbi_axil_slave.sv]
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// axi4-lite slave front end
// ----------------------------------------
module mbi_axil_slave (
    input wire logic clk_i,            // system clock
    input wire logic sys_rst_i,        // synchronous reset, active high
    input wire logic [7:0] awaddr_i,   // write address
    input wire logic awvalid_i,        // write address valid
    output logic awready_o,            // write address ready
    input wire logic [31:0] wdata_i,   // write data
    input wire logic [3:0] wstrb_i,    // write byte strobes
    input wire logic wvalid_i,         // write data valid
    output logic wready_o,             // write data ready
    output logic [1:0] bresp_o,        // write response
    output logic bvalid_o,             // write response valid
    input wire logic bready_i,         // write response ready
    input wire logic [7:0] araddr_i,   // read address
    input wire logic arvalid_i,        // read address valid
    output logic arready_o,            // read address ready
    output logic [31:0] rdata_o,       // read data
    output logic [1:0] rresp_o,        // read response
    output logic rvalid_o,             // read data valid
    input wire logic rready_i,         // read data ready
    output logic wr_en_o,              // one-cycle register write
    output logic [7:0] wr_addr_o,      // held write address
    output logic [31:0] wr_data_o,     // held write data
    output logic [3:0] wr_strb_o,      // held byte strobes
    input wire logic wr_ok_i,          // write address is mapped
    output logic [7:0] rd_addr_o,      // read address for decode
    input wire logic [31:0] rd_data_i, // decoded read data
    input wire logic rd_ok_i           // read address is mapped
);
    logic aw_held;
    logic w_held;

    assign wr_en_o = aw_held & w_held & ~bvalid_o;
    assign rd_addr_o = araddr_i;

    // write channels: each taken once, in either order, then answered
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready_o <= 1'b1;
            wready_o <= 1'b1;
            bvalid_o <= 1'b0;
            bresp_o <= mbi_pkg::RESP_OKAY;
            wr_addr_o <= 8'h00;
            wr_data_o <= 32'h0000_0000;
            wr_strb_o <= 4'h0;
        end else begin
            if (awvalid_i && awready_o) begin
                aw_held <= 1'b1;
                awready_o <= 1'b0;
                wr_addr_o <= awaddr_i;
            end
            if (wvalid_i && wready_o) begin
                w_held <= 1'b1;
                wready_o <= 1'b0;
                wr_data_o <= wdata_i;
                wr_strb_o <= wstrb_i;
            end
            if (wr_en_o) begin
                bvalid_o <= 1'b1;
                bresp_o <= wr_ok_i ? mbi_pkg::RESP_OKAY : mbi_pkg::RESP_SLVERR;
            end
            if (bvalid_o && bready_i) begin
                bvalid_o <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                awready_o <= 1'b1;
                wready_o <= 1'b1;
            end
        end
    end

    // read channel: data captured at the address handshake
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            arready_o <= 1'b1;
            rvalid_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
            rresp_o <= mbi_pkg::RESP_OKAY;
        end else if (arvalid_i && arready_o) begin
            arready_o <= 1'b0;
            rvalid_o <= 1'b1;
            rdata_o <= rd_ok_i ? rd_data_i : 32'h0000_0000;
            rresp_o <= rd_ok_i ? mbi_pkg::RESP_OKAY : mbi_pkg::RESP_SLVERR;
        end else if (rvalid_o && rready_i) begin
            rvalid_o <= 1'b0;
            arready_o <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// [tb/mbi_dev_model.sv]
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// far-side device model
// ----------------------------------------
module mbi_dev_model (
    input wire logic clk_i,              // system clock
    input wire logic [5:0] cfg_i,        // device setup, same bits as host control
    input wire logic [7:0] host_lanes_i, // host lane value
    input wire logic host_oe_i,          // host drives lanes
    input wire logic ale_i,              // latch strobe, polarity by setup
    input wire logic wr_i,               // write strobe or direction select
    input wire logic rd_i,               // read strobe or enable clock
    input wire logic prog_i,             // program read strobe, active low
    input wire logic sel_i,              // select, active low in select mode
    input wire logic rst_i,              // device reset, polarity by setup
    output logic [7:0] lanes_o           // resolved lane level
);
    logic [7:0] mem [256];
    logic [7:0] la; // latched address, kept between cycles
    logic [7:0] last;
    logic dev_oe;
    logic ale_on;
    logic rst_on;
    assign ale_on = ale_i ~^ cfg_i[2];
    assign rst_on = rst_i ~^ (cfg_i[4] && !cfg_i[5]);
    // drives only while selected and a read control is active
    assign dev_oe = !(cfg_i[3] && sel_i)
        && ((cfg_i[1] ? rd_i && wr_i : !rd_i) || !prog_i);
    // released lanes show the inverse of the last level, never a stale copy
    assign lanes_o = host_oe_i ? host_lanes_i : dev_oe ? (!prog_i ? ~la : mem[la]) : ~last;
    always_ff @(posedge clk_i) last <= lanes_o;
    // trailing edge of the strobe captures the address; reset clears it
    always @(negedge ale_on or posedge rst_on) la <= rst_on ? 8'h00 : host_lanes_i;
    // strobe style takes data at the rising strobe, direction style at the falling enable
    always @(posedge wr_i) if (!rst_on && !cfg_i[0]) mem[la] <= lanes_o;
    always @(negedge rd_i) if (!rst_on && cfg_i[0] && !wr_i) mem[la] <= lanes_o;
endmodule

`default_nettype wire

// [tb/mcu_bus_interface_power_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

// ----------------------------------------
// bench top
// ----------------------------------------
module mcu_bus_interface_power_bench;
    logic clk_i, sys_rst_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i;
    logic [7:0] s_awaddr_i, s_araddr_i, mux_byte_lanes_i, mux_byte_lanes_o, high_order_address_inputs_o;
    logic [31:0] s_wdata_i, s_rdata_o, d;
    logic [1:0] s_bresp_o, s_rresp_o, r;
    logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, mux_byte_lanes_oe_o;
    logic address_latch_strobe_o, write_ctl_o, read_ctl_o, program_space_read_strobe_o;
    logic select_or_extra_address_pin_o, dev_reset_o;
    int errors = 0;
    int total_checks = 0;
    logic [5:0] rc [3] = '{6'h14, 6'h1C, 6'h03};
    logic [16:0] ra [3] = '{17'h1_00A5, 17'h0_025A, 17'h0_00FF};
    logic [7:0] rv [3] = '{8'h3C, 8'hC3, 8'h96};
    logic [5:0] cfg = 6'h14;

    mbi_host dut (.clk_i, .sys_rst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i,
        .s_wstrb_i(4'hF), .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i,
        .s_araddr_i, .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o,
        .s_rready_i, .mux_byte_lanes_i, .mux_byte_lanes_o, .mux_byte_lanes_oe_o,
        .high_order_address_inputs_o, .address_latch_strobe_o, .write_ctl_o, .read_ctl_o,
        .program_space_read_strobe_o, .select_or_extra_address_pin_o, .dev_reset_o);
    mbi_dev_model dev (.clk_i, .host_lanes_i(mux_byte_lanes_o), .host_oe_i(mux_byte_lanes_oe_o),
        .ale_i(address_latch_strobe_o), .wr_i(write_ctl_o), .rd_i(read_ctl_o),
        .prog_i(program_space_read_strobe_o), .sel_i(select_or_extra_address_pin_o), .cfg_i(cfg),
        .rst_i(dev_reset_o), .lanes_o(mux_byte_lanes_i));

    // clock, 10 ns period
    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end

    // axi writes: address and data offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge clk_i);
        s_awaddr_i <= a;
        s_wdata_i <= v;
        s_awvalid_i <= 1'b1;
        s_wvalid_i <= 1'b1;
        s_bready_i <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk_i);
            aw_done |= s_awready_o;
            w_done |= s_wready_o;
            s_awvalid_i <= !aw_done;
            s_wvalid_i <= !w_done;
        end
        while (!s_bvalid_o) @(posedge clk_i);
        r = s_bresp_o;
        s_bready_i <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge clk_i);
        s_araddr_i <= a;
        s_arvalid_i <= 1'b1;
        s_rready_i <= 1'b1;
        do @(posedge clk_i); while (!s_arready_o);
        s_arvalid_i <= 1'b0;
        do @(posedge clk_i); while (!s_rvalid_o);
        d = s_rdata_o;
        r = s_rresp_o;
        s_rready_i <= 1'b0;
    endtask

    // poll status until the cycle has ended; bounded so a hang shows up
    task automatic idle;
        d = 32'h1;
        repeat (100) if (d[0]) axr(mbi_pkg::REG_STATUS);
        `CHK("busy", 1'b0, d[0])
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence: reset, table of cycles, then odd cases
    initial begin
        {s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = '0;
        {s_awaddr_i, s_araddr_i, s_wdata_i} = '0;
        sys_rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        axr(mbi_pkg::REG_STATUS);
        `CHK("dev_reset", 2'b11, {d[1], dev_reset_o})
        axr(mbi_pkg::REG_CTRL);
        `CHK("ctrl", mbi_pkg::CTRL_RESET, d[5:0])
        idle();
        for (int i = 0; i < 3; i++) begin
            axw(mbi_pkg::REG_CTRL, {26'h0, rc[i]});
            cfg <= rc[i];
            axw(mbi_pkg::REG_ADDR, {15'h0, ra[i]});
            axw(mbi_pkg::REG_WDATA, {24'h0, rv[i]});
            axw(mbi_pkg::REG_CMD, 32'h1);
            `CHK("select", rc[i][3] ? 1'b0 : ra[i][16], select_or_extra_address_pin_o)
            idle();
            `CHK("high_addr", ra[i][15:8], high_order_address_inputs_o)
            `CHK("idle_ctl", {1'b1, !rc[i][1]}, {write_ctl_o, read_ctl_o})
            `CHK("idle_lanes", 2'b10, {program_space_read_strobe_o, mux_byte_lanes_oe_o})
            axw(mbi_pkg::REG_CMD, 32'h2);
            idle();
            `CHK("data", rv[i], d[15:8])
            axw(mbi_pkg::REG_CMD, 32'h4);
            idle();
            `CHK("prog", ~ra[i][7:0], d[15:8])
        end
        axr(8'h14);
        `CHK("unmapped", {mbi_pkg::RESP_SLVERR, 32'h0}, {r, d})
        axr(mbi_pkg::REG_CMD);
        `CHK("cmd_read", 32'h0, d)
        // low-voltage reset: active low, then a quiet spell before the next cycle
        axw(mbi_pkg::REG_CTRL, 32'h20);
        cfg <= 6'h20;
        axw(mbi_pkg::REG_CMD, 32'h8);
        axr(mbi_pkg::REG_STATUS);
        `CHK("lv_reset", 2'b10, {d[1], dev_reset_o})
        idle();
        axw(mbi_pkg::REG_CMD, 32'h2);
        idle();
        `CHK("lv_data", {rv[2], 1'b1}, {d[15:8], dev_reset_o})
        report_and_stop();
    end

    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        report_and_stop();
    end
endmodule

`default_nettype wire
